// >>> tcw_write_port.sv
// transmit cell/packet write port: capture, checks, cell buffer, idle fill
// Functional notes
// - cell mode: bus carries cell octets
// - packet mode: bus carries packet octets
// - accept only when enabled and addressed
// - capture on interface clock rising edge
// - parity mismatch sets status, maskable interrupt
// - cells with parity errors still forwarded
// - packets with parity errors still forwarded
// - odd or even parity by config
// - parity checked only on accepted words
// - parity sampled on interface clock edge
// - cell marker flags first word
// - marker optional, words counted for boundaries
// - misplaced cell marker raises interrupt
// - cell marker honoured only on accepted words
// - cell marker sampled on interface clock edge
// - active-low enable; high latches address only
// - forward full cells, else idle cells
// - select on own address, never 0x7
`timescale 1ns/1ps
module tcw_write_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_interface_clock,
  input wire logic [15:0] tx_word_bus,
  input wire logic tx_write_enable_n,
  input wire logic [2:0] tx_port_select,
  input wire logic tx_word_parity,
  input wire logic tx_cell_first_word,
  input wire logic tx_packet_first_word,
  input wire logic [2:0] phy_address,
  input wire logic packet_mode,
  input wire logic parity_sense_select,
  input wire logic parity_irq_enable,
  input wire logic marker_irq_enable,
  input wire logic status_clear,
  input wire logic out_ready,
  output logic [15:0] out_word,
  output logic out_valid,
  output logic out_first,
  output logic out_idle,
  output logic out_parity_err,
  output logic parity_err_status,
  output logic marker_err_status,
  output logic irq
);
  // everything from the link passes two flops; 800 ns link vs 100 ns clk leaves margin
  localparam int PW = 24;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  logic lclk_s;
  logic lclk_prev_q;
  logic lclk_prev_d;
  logic [15:0] s_word;
  logic s_wen_n;
  logic [2:0] s_adr;
  logic s_par;
  logic s_soc;
  logic s_sop;
  logic link_edge;

  assign pin_raw = {tx_interface_clock, tx_word_bus, tx_write_enable_n, tx_port_select,
                    tx_word_parity, tx_cell_first_word, tx_packet_first_word};

  tcw_sync #(.W(PW)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(pin_raw),
    .dout(pin_s)
  );

  assign {lclk_s, s_word, s_wen_n, s_adr, s_par, s_soc, s_sop} = pin_s;
  // data is steady across the link edge, so the synced copy at the edge is valid
  assign link_edge = lclk_s & ~lclk_prev_q;

  // selection and acceptance
  logic [2:0] sel_adr_q;
  logic [2:0] sel_adr_d;
  logic selected;
  logic accept;

  assign selected = (sel_adr_q == phy_address) && (sel_adr_q != tcw_pkg::NULL_ADDR);
  assign accept = link_edge && !s_wen_n && selected;

  // parity check: even sense means the 17 bits xor to zero
  logic par_bad;
  assign par_bad = accept && ((^s_word ^ s_par) != parity_sense_select);

  // cell word counter and buffer
  logic [4:0] widx_q;
  logic [4:0] widx_d;
  logic marker_bad;
  logic cell_start;
  logic [15:0] buf_mem [tcw_pkg::CELL_BUF_WORDS];
  logic buf_full_q;
  logic buf_full_d;
  logic buf_err_q;
  logic buf_err_d;
  logic [4:0] rd_idx_q;
  logic [4:0] rd_idx_d;
  logic first_fill;

  assign cell_start = s_soc && !packet_mode;
  assign marker_bad = accept && cell_start && (widx_q != tcw_pkg::WORD_IDX_RST);
  // words accepted while the buffer is full are dropped; limitation: no cell-available flag
  assign first_fill = accept && !packet_mode && !buf_full_q;

  logic [15:0] ow_q;
  logic [15:0] ow_d;
  logic ov_q;
  logic ov_d;
  logic of_q;
  logic of_d;
  logic oi_q;
  logic oi_d;
  logic oe_q;
  logic oe_d;
  logic pst_q;
  logic pst_d;
  logic mst_q;
  logic mst_d;
  logic [4:0] idle_idx_q;
  logic [4:0] idle_idx_d;
  logic out_busy;

  assign out_busy = ov_q && !out_ready;

  always_comb begin
    sel_adr_d = sel_adr_q;
    lclk_prev_d = lclk_s;
    widx_d = widx_q;
    buf_full_d = buf_full_q;
    buf_err_d = buf_err_q;
    rd_idx_d = rd_idx_q;
    idle_idx_d = idle_idx_q;
    ow_d = ow_q;
    ov_d = ov_q;
    of_d = of_q;
    oi_d = oi_q;
    oe_d = oe_q;
    if (link_edge) begin
      sel_adr_d = s_adr;
    end
    // set wins over clear
    pst_d = (pst_q && !status_clear) || par_bad;
    mst_d = (mst_q && !status_clear) || marker_bad;
    if (first_fill) begin
      // marker restarts the count; otherwise words are counted
      if (cell_start || widx_q == tcw_pkg::LAST_WORD_IDX) begin
        widx_d = cell_start ? 5'h01 : tcw_pkg::WORD_IDX_RST;
      end else begin
        widx_d = widx_q + 5'h01;
      end
      // an error flag belongs to one cell only, so a counted boundary clears it too
      buf_err_d = ((cell_start || widx_q == tcw_pkg::WORD_IDX_RST) ? 1'b0 : buf_err_q)
                  || par_bad;
      if (widx_q == tcw_pkg::LAST_WORD_IDX && !cell_start) begin
        buf_full_d = 1'b1;
      end
    end
    if (!out_busy) begin
      ov_d = 1'b1;
      if (packet_mode) begin
        // packets flow straight through, errored or not
        ov_d = accept;
        ow_d = s_word;
        of_d = s_sop;
        oi_d = 1'b0;
        oe_d = par_bad;
      end else if (buf_full_q && idle_idx_q == tcw_pkg::WORD_IDX_RST) begin
        ow_d = buf_mem[rd_idx_q];
        of_d = (rd_idx_q == tcw_pkg::WORD_IDX_RST);
        oi_d = 1'b0;
        oe_d = buf_err_q;
        if (rd_idx_q == tcw_pkg::LAST_WORD_IDX) begin
          rd_idx_d = tcw_pkg::WORD_IDX_RST;
          buf_full_d = 1'b0;
        end else begin
          rd_idx_d = rd_idx_q + 5'h01;
        end
      end else begin
        // idle cells run whole so a real cell never splits one
        ow_d = tcw_pkg::IDLE_WORD;
        of_d = (idle_idx_q == tcw_pkg::WORD_IDX_RST);
        oi_d = 1'b1;
        oe_d = 1'b0;
        idle_idx_d = (idle_idx_q == tcw_pkg::LAST_WORD_IDX) ? tcw_pkg::WORD_IDX_RST
                                                            : idle_idx_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (first_fill) begin
      // a marked word always opens the cell at slot zero
      buf_mem[cell_start ? tcw_pkg::WORD_IDX_RST : widx_q] <= s_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_adr_q <= tcw_pkg::NULL_ADDR;
      lclk_prev_q <= 1'b0;
      widx_q <= tcw_pkg::WORD_IDX_RST;
      buf_full_q <= 1'b0;
      buf_err_q <= 1'b0;
      rd_idx_q <= tcw_pkg::WORD_IDX_RST;
      idle_idx_q <= tcw_pkg::WORD_IDX_RST;
      ow_q <= tcw_pkg::IDLE_WORD;
      ov_q <= 1'b0;
      of_q <= 1'b0;
      oi_q <= 1'b0;
      oe_q <= 1'b0;
      pst_q <= 1'b0;
      mst_q <= 1'b0;
    end else begin
      sel_adr_q <= sel_adr_d;
      lclk_prev_q <= lclk_prev_d;
      widx_q <= widx_d;
      buf_full_q <= buf_full_d;
      buf_err_q <= buf_err_d;
      rd_idx_q <= rd_idx_d;
      idle_idx_q <= idle_idx_d;
      ow_q <= ow_d;
      ov_q <= ov_d;
      of_q <= of_d;
      oi_q <= oi_d;
      oe_q <= oe_d;
      pst_q <= pst_d;
      mst_q <= mst_d;
    end
  end

  assign out_word = ow_q;
  assign out_valid = ov_q;
  assign out_first = of_q;
  assign out_idle = oi_q;
  assign out_parity_err = oe_q;
  assign parity_err_status = pst_q;
  assign marker_err_status = mst_q;
  assign irq = (pst_q && parity_irq_enable) || (mst_q && marker_irq_enable);
endmodule : tcw_write_port

// >>> tcw_pkg.sv
// package: constants for the transmit cell/packet write port
package tcw_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 3;
  localparam logic [2:0] NULL_ADDR = 3'h7;
  // 53 octets in 16-bit words: 27 words, last one half used
  localparam int CELL_OCTETS = 53;
  localparam int CELL_WORDS = (CELL_OCTETS + 1) / 2;
  localparam logic [4:0] WORD_IDX_RST = 5'h00;
  localparam logic [4:0] LAST_WORD_IDX = 5'(CELL_WORDS - 1);
  localparam logic [15:0] IDLE_WORD = 16'h0000;
  localparam int LINK_CLK_NS = 800;
  localparam int SYS_CLK_NS = 100;
  localparam int SYNC_STAGES = 2;
  localparam int CELL_BUF_WORDS = 32;
  typedef enum logic [1:0] {
    TCW_CELL = 2'b01,
    TCW_PACKET = 2'b10
  } tcw_mode_t;
endpackage : tcw_pkg

// >>> tcw_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module tcw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule : tcw_sync

// >>> tcw_write_port_assertions.sv
// checker: port-level properties of the transmit write port
`timescale 1ns/1ps
module tcw_write_port_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic packet_mode,
  input wire logic status_clear,
  input wire logic parity_irq_enable,
  input wire logic marker_irq_enable,
  input wire logic out_ready,
  input wire logic [15:0] out_word,
  input wire logic out_valid,
  input wire logic out_idle,
  input wire logic parity_err_status,
  input wire logic marker_err_status,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  irq_map_a:
    assert property (irq == (parity_err_status && parity_irq_enable
      || marker_err_status && marker_irq_enable)) else $error("irq mismatch");
  out_hold_a:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
      else $error("stalled word moved");
  par_keep_a:
    assert property (parity_err_status && !status_clear |=> parity_err_status)
      else $error("parity status lost");
  mark_keep_a:
    assert property (marker_err_status && !status_clear |=> marker_err_status)
      else $error("marker status lost");
  idle_zero_a:
    assert property (out_idle |-> out_valid && out_word == 16'h0000) else $error("idle not zero");
  idle_cell_a:
    assert property (out_idle |-> !packet_mode) else $error("idle in packet mode");
  mark_mode_a:
    assert property ($rose(marker_err_status) |-> !packet_mode) else $error("marker in packet");
  rst_quiet_a:
    assert property (disable iff (1'h0) rst |=> !out_valid && !parity_err_status && !irq)
      else $error("reset left outputs set");
  cover property ($rose(parity_err_status));
  cover property ($rose(marker_err_status));
  cover property (out_valid && !out_idle && !out_ready);
endmodule : tcw_write_port_assertions

// >>> tcw_upstream_model.sv
// upstream writer model: one link clock cycle per call
`timescale 1ns/1ps
module tcw_upstream_model (
  output logic tx_interface_clock,
  output logic [15:0] tx_word_bus,
  output logic tx_write_enable_n,
  output logic [2:0] tx_port_select,
  output logic tx_word_parity,
  output logic tx_cell_first_word,
  output logic tx_packet_first_word
);
  initial begin
    {tx_interface_clock, tx_word_bus, tx_word_parity} = '0;
    {tx_write_enable_n, tx_port_select, tx_cell_first_word, tx_packet_first_word} = '1;
  end
  // clock runs only inside a call, so no edge ever lands on a half-changed bus
  task automatic put(input logic [15:0] w, input logic en_n, input logic [2:0] a,
    input logic first, input logic odd, input logic bad);
    {tx_word_bus, tx_write_enable_n, tx_port_select} = {w, en_n, a};
    tx_word_parity = ^w ^ odd ^ bad;
    {tx_cell_first_word, tx_packet_first_word} = {2{first}};
    #437 tx_interface_clock = 1'h1;
    #363 tx_interface_clock = 1'h0;
  endtask : put
endmodule : tcw_upstream_model

// >>> tcw_write_port_test.sv
// self-checking bench for the transmit write port
`timescale 1ns/1ps
module tcw_write_port_test;
  typedef struct packed {
    logic [2:0] phy;
    logic [2:0] adr;
    logic en_n;
    logic odd;
    logic bad;
    logic [15:0] w;
    logic acc;
  } tcw_row_t;
  logic clk, rst, packet_mode, parity_sense_select, parity_irq_enable, marker_irq_enable;
  logic status_clear, out_ready, out_valid, out_first, out_idle, irq, tx_interface_clock;
  logic parity_err_status, marker_err_status, tx_write_enable_n, tx_word_parity;
  logic tx_cell_first_word, tx_packet_first_word, out_parity_err;
  logic [2:0] phy_address, tx_port_select;
  logic [15:0] out_word, tx_word_bus;
  int err_total, samples_checked, k;
  tcw_row_t rows [7] = '{
    '{3'h2, 3'h2, 1'h0, 1'h0, 1'h0, 16'h1234, 1'h1},
    '{3'h2, 3'h2, 1'h0, 1'h1, 1'h1, 16'h00ff, 1'h1},
    '{3'h2, 3'h2, 1'h0, 1'h0, 1'h1, 16'ha5a5, 1'h1},
    '{3'h2, 3'h2, 1'h0, 1'h1, 1'h0, 16'h8001, 1'h1},
    '{3'h2, 3'h2, 1'h1, 1'h1, 1'h1, 16'h0001, 1'h0},
    '{3'h2, 3'h3, 1'h0, 1'h0, 1'h1, 16'hffff, 1'h0},
    '{3'h7, 3'h7, 1'h0, 1'h0, 1'h1, 16'h0f0f, 1'h0}};
  tcw_upstream_model up_u (.tx_interface_clock, .tx_word_bus, .tx_write_enable_n,
    .tx_port_select, .tx_word_parity, .tx_cell_first_word, .tx_packet_first_word);
  tcw_write_port dut_u (.clk, .rst, .tx_interface_clock, .tx_word_bus, .tx_write_enable_n,
    .tx_port_select, .tx_word_parity, .tx_cell_first_word, .tx_packet_first_word,
    .phy_address, .packet_mode, .parity_sense_select, .parity_irq_enable,
    .marker_irq_enable, .status_clear, .out_ready, .out_word, .out_valid, .out_first,
    .out_idle, .out_parity_err, .parity_err_status, .marker_err_status, .irq);
  always #50 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse_clear;
    status_clear = 1'h1;
    tick(1);
    status_clear = 1'h0;
  endtask : pulse_clear
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    #2_000_000;
    err_total++;
    summarize;
  end
  initial begin
    {clk, status_clear, out_ready, parity_sense_select, err_total, samples_checked} = '0;
    {rst, parity_irq_enable, marker_irq_enable, packet_mode} = '1;
    phy_address = 3'h2;
    tick(6);
    rst = 1'h0;
    tick(3);
    chk(irq, 1'h0);
    // out_ready stays low so an accepted word waits at the output
    foreach (rows[i]) begin
      phy_address = rows[i].phy;
      parity_sense_select = rows[i].odd;
      up_u.put(~rows[i].w, 1'h1, rows[i].adr, 1'h1, rows[i].odd, 1'h1);
      up_u.put(rows[i].w, rows[i].en_n, rows[i].adr, 1'h1, rows[i].odd, rows[i].bad);
      tick(8);
      chk(out_valid, rows[i].acc);
      if (rows[i].acc) begin
        chk(out_word, rows[i].w);
        chk(out_first, 1'h1);
      end
      chk(out_parity_err, rows[i].acc & rows[i].bad);
      chk(parity_err_status, rows[i].acc & rows[i].bad);
      chk(irq, rows[i].acc & rows[i].bad);
      out_ready = 1'h1;
      pulse_clear;
      out_ready = 1'h0;
    end
    {packet_mode, parity_irq_enable, parity_sense_select, rst} = 4'h1;
    phy_address = 3'h2;
    tick(6);
    {rst, out_ready} = 2'h1;
    tick(3);
    chk(out_idle, 1'h1);
    chk(out_word, 16'h0000);
    up_u.put(16'h0000, 1'h1, 3'h2, 1'h0, 1'h0, 1'h0);
    // no start marker: the boundary comes from the word count alone
    for (k = 0; k < 27; k++)
      up_u.put(16'h0100 + 16'(k), 1'h0, 3'h2, 1'h0, 1'h0, k == 3);
    for (k = 0; k < 200 && {out_valid, out_first, out_idle} !== 3'h6; k++)
      tick(1);
    chk(out_word, 16'h0100);
    chk(out_first, 1'h1);
    chk(out_idle, 1'h0);
    chk(out_parity_err, 1'h1);
    chk(parity_err_status, 1'h1);
    chk(irq, 1'h0);
    // let the whole cell drain so the next words find an empty buffer
    for (k = 1; k < 27; k++) begin
      tick(1);
      chk(out_word, 16'h0100 + 16'(k));
    end
    pulse_clear;
    chk(parity_err_status, 1'h0);
    for (k = 0; k < 2; k++)
      up_u.put(16'h0300, 1'h0, 3'h2, 1'h0, 1'h0, 1'h0);
    up_u.put(16'h0302, 1'h1, 3'h2, 1'h1, 1'h0, 1'h0);
    tick(6);
    chk(marker_err_status, 1'h0);
    up_u.put(16'h0302, 1'h0, 3'h2, 1'h1, 1'h0, 1'h0);
    tick(6);
    chk(marker_err_status, 1'h1);
    chk(irq, 1'h1);
    // rest of the restarted cell; the marked word must lead it
    for (k = 1; k < 27; k++)
      up_u.put(16'h0400 + 16'(k), 1'h0, 3'h2, 1'h0, 1'h0, 1'h0);
    for (k = 0; k < 200 && {out_valid, out_first, out_idle} !== 3'h6; k++)
      tick(1);
    chk(out_first, 1'h1);
    chk(out_word, 16'h0302);
    chk(out_parity_err, 1'h0);
    summarize;
  end
endmodule : tcw_write_port_test
bind tcw_write_port tcw_write_port_assertions chk_u (.clk, .rst, .packet_mode, .status_clear,
  .parity_irq_enable, .marker_irq_enable, .out_ready, .out_word, .out_valid, .out_idle,
  .parity_err_status, .marker_err_status, .irq);
